// >>> bench/pll_config_bank_monitor.sv
`timescale 1ns/1ps
module pll_cfg_monitor (
    input wire I_CORE_CLK, // clock
    input wire I_RSTN, // reset
    input wire I_WB_CYC, // cycle
    input wire I_WB_STB, // strobe
    input wire [31:0] O_WB_DAT, // read data
    input wire O_WB_ACK, // ack
    input wire O_WB_ERR, // error
    input wire I_DPLL_EXTERNAL_SWITCH_MODE, // dpll switch mode
    input wire [1:0] O_ALIGN_PULSE, // align pulses
    input wire [7:0] O_INDIV_RATIO, // input ratios
    input wire [5:0] O_SOURCE_SEL, // sources
    input wire O_SWITCH_PIN_ACTIVE // pin role
);
default clocking @(posedge I_CORE_CLK); endclocking
default disable iff (!I_RSTN);
chk_ack_next_cycle: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("ack late");
chk_ack_one_cycle: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held");
chk_ack_has_cause: assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB))
    else $error("stray ack");
chk_err_unused: assert property (!O_WB_ERR)
    else $error("err raised");
chk_upper_zero: assert property (O_WB_DAT[31:8] == 24'h0)
    else $error("upper data set");
chk_align_single: assert property (|O_ALIGN_PULSE |=> O_ALIGN_PULSE == 2'h0)
    else $error("align pulse long");
chk_ratio_legal: assert property (O_INDIV_RATIO[3:0] inside {4'h1, 4'h2, 4'h4, 4'h8}
    && O_INDIV_RATIO[7:4] inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("bad ratio");
chk_source_code: assert property (O_SOURCE_SEL[2:0] != 3'h6 && O_SOURCE_SEL[5:3] != 3'h6)
    else $error("bad source");
chk_dpll_pin_role: assert property (I_DPLL_EXTERNAL_SWITCH_MODE [*5] |-> O_SWITCH_PIN_ACTIVE)
    else $error("pin role lost");
cover property (O_WB_ACK);
cover property (|O_ALIGN_PULSE);
cover property (O_SWITCH_PIN_ACTIVE);
endmodule

// >>> bench/tb_pll_config_bank.sv
`timescale 1ns/1ps
module tb_pll_config_bank;
reg clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, pin = 0, dsw = 0, xtal = 0, e1;
reg [9:0] adr = 0;
reg [31:0] wdat = 0;
reg [3:0] sel = 0;
reg [7:0] q, c1, c2, c3;
wire [31:0] rdat;
wire ack, err, act;
wire [1:0] en, byp, alp;
wire [7:0] hs, rat;
wire [5:0] src;
integer error_cnt = 0, cmp_count = 0, seed = 4, i, p0 = 0, p1 = 0;
pll_config_bank uut (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .O_WB_ERR(err), .I_SWITCH_PIN(pin), .I_DPLL_EXTERNAL_SWITCH_MODE(dsw),
    .I_CRYSTAL_PRESENT(xtal), .O_PLL_ENABLE(en), .O_PLL_BYPASS(byp), .O_ALIGN_PULSE(alp),
    .O_HIGH_SPEED_DIVIDER_HALVES(hs), .O_INDIV_RATIO(rat), .O_SOURCE_SEL(src), .O_SWITCH_PIN_ACTIVE(act));
initial forever #2 clk = ~clk;
always @(posedge clk) begin
    p0 = p0 + alp[0];
    p1 = p1 + alp[1];
end
////////////////////////////////////////////////////////////////////////////////
task chk(input [31:0] got, input [31:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    end
endtask
task wb(input w, input [9:0] a, input [7:0] d, input [3:0] s);
    begin
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        sel <= s;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat[7:0];
        cyc <= 0;
        stb <= 0;
    end
endtask
task rd(input [9:0] a, input [7:0] e);
    begin
        wb(0, a, 8'h00, 4'hF);
        chk(q, e);
    end
endtask
task close_out;
    begin
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    end
endtask
function [2:0] dec(input [2:0] c);
    dec = c == 3'h2 ? {2'h1, ~xtal} : c == 3'h3 ? 3'h4 : c == 3'h5 ? 3'h7 : c[2] ? 3'h5 : c;
endfunction
function [2:0] src_of(input [7:0] r);
    src_of = r[5] && pin ? dec({1'b0, r[4:3]}) : dec(r[2:0]);
endfunction
////////////////////////////////////////////////////////////////////////////////
initial begin
    #100000;
    error_cnt = error_cnt + 1;
    close_out;
end
initial begin
    repeat (20) @(posedge clk);
    rstn <= 1;
    rd(10'h040, 8'h01);
    rd(10'h044, 8'h00);
    rd(10'h048, 8'h00);
    wb(1, 10'h040, 8'h00, 4'hF);
    wb(1, 10'h044, 8'hFF, 4'hF);
    rd(10'h044, 8'h00);
    wb(1, 10'h040, 8'h03, 4'hF);
    rd(10'h048, 8'h00);
    rd(10'h3FC, 8'h00);
    wb(1, 10'h040, 8'h01, 4'hF);
    rd(10'h044, 8'h00);
    for (i = 0; i < 32; i = i + 1) begin
        c1 = $random(seed) & 8'hDF;
        c2 = ($random(seed) & 8'hF8) | i[2:0];
        e1 = $random(seed);
        c3 = {~c2[7:6], e1, ~c2[4:0]};
        pin <= $random(seed);
        xtal <= $random(seed);
        dsw <= $random(seed);
        wb(1, 10'h040, 8'h01, 4'hF);
        wb(1, 10'h044, c1, 4'hF);
        wb(1, 10'h048, c3, 4'hF);
        wb(1, 10'h040, 8'h02, 4'hF);
        wb(1, 10'h044, ~c1 & 8'hDF, 4'hF);
        wb(1, 10'h048, c2, 4'hF);
        rd(10'h044, ~c1 & 8'hCF);
        rd(10'h048, c2);
        wb(1, 10'h040, 8'h01, 4'hF);
        rd(10'h044, c1 & 8'hCF);
        rd(10'h048, c3);
        repeat (3) @(posedge clk);
        chk(en, {~c1[7], c1[7]});
        chk(byp, {~c1[6], c1[6]});
        chk(hs, {~c1[3:0], c1[3:0]});
        chk(rat, {4'h1 << c2[7:6], 4'h1 << c3[7:6]});
        chk(src, {src_of(c2), src_of(c3)});
        chk(act, c2[5] | c3[5] | dsw);
    end
    p0 = 0;
    p1 = 0;
    wb(1, 10'h044, 8'h20, 4'hF);
    wb(1, 10'h044, 8'h20, 4'hF);
    wb(1, 10'h044, 8'h00, 4'hF);
    wb(1, 10'h044, 8'h20, 4'hF);
    wb(1, 10'h044, 8'hFF, 4'hE);
    rd(10'h044, 8'h20);
    repeat (4) @(posedge clk);
    chk(p0, 2);
    chk(p1, 0);
    close_out;
end
endmodule
bind pll_config_bank pll_cfg_monitor mon (.I_CORE_CLK, .I_RSTN, .I_WB_CYC, .I_WB_STB,
    .O_WB_DAT, .O_WB_ACK, .O_WB_ERR, .I_DPLL_EXTERNAL_SWITCH_MODE, .O_ALIGN_PULSE, .O_INDIV_RATIO,
    .O_SOURCE_SEL, .O_SWITCH_PIN_ACTIVE);

// >>> logic/pll_config_bank.v
`timescale 1ns/1ps
`include "pll_config_map.vh"

module pll_config_bank (
    input wire I_CORE_CLK, // core clock 250 MHz
    input wire I_RSTN, // async reset, active low
    input wire I_WB_CYC, // wishbone cycle
    input wire I_WB_STB, // wishbone strobe
    input wire I_WB_WE, // wishbone write enable
    input wire [9:0] I_WB_ADR, // byte address
    input wire [3:0] I_WB_SEL, // byte lanes
    input wire [31:0] I_WB_DAT, // write data
    output reg [31:0] O_WB_DAT, // read data
    output reg O_WB_ACK, // acknowledge
    output wire O_WB_ERR, // tied low, unmapped addresses are acked
    input wire I_SWITCH_PIN, // shared source-switch pin
    input wire I_DPLL_EXTERNAL_SWITCH_MODE, // dpll external switching on
    input wire I_CRYSTAL_PRESENT, // crystal fitted
    output wire [1:0] O_PLL_ENABLE, // per pll enable
    output wire [1:0] O_PLL_BYPASS, // per pll bypass
    output wire [1:0] O_ALIGN_PULSE, // divider align reset pulse
    output wire [7:0] O_HIGH_SPEED_DIVIDER_HALVES, // per pll high-speed divider code, 4 bits each
    output wire [7:0] O_INDIV_RATIO, // per pll input divide ratio, 4 bits each
    output wire [5:0] O_SOURCE_SEL, // per pll decoded source, 3 bits each
    output reg O_SWITCH_PIN_ACTIVE // pin acts as source switch
);

    //////////////////////////////////////////////////////////////////////
    // source codes driven on O_SOURCE_SEL
    localparam [2:0] SRC_IN_ONE = 3'h0;
    localparam [2:0] SRC_IN_TWO = 3'h1;
    localparam [2:0] SRC_CRYSTAL_BLOCK = 3'h2;
    localparam [2:0] SRC_CRYSTAL_PIN = 3'h3;
    localparam [2:0] SRC_MASTER = 3'h4;
    localparam [2:0] SRC_DPLL = 3'h5;
    localparam [2:0] SRC_NONE = 3'h7;

    //////////////////////////////////////////////////////////////////////
    // decoders

    // only codes 01 and 10 map a pll into the window
    function bank_valid;
        input [1:0] code;
        begin
            bank_valid = (code == `BANK_PLL_ONE) || (code == `BANK_PLL_TWO);
        end
    endfunction

    // register index compare, shared by all address decodes
    function reg_hit;
        input [7:0] index;
        input [7:0] offset;
        begin
            reg_hit = (index == offset);
        end
    endfunction

    function [3:0] in_ratio;
        input [1:0] code;
        begin
            in_ratio = 4'h1 << code;
        end
    endfunction

    function [2:0] src_decode;
        input [2:0] code;
        input crystal;
        begin
            case (code)
                3'h0: src_decode = SRC_IN_ONE;
                3'h1: src_decode = SRC_IN_TWO;
                3'h2: src_decode = crystal ? SRC_CRYSTAL_BLOCK : SRC_CRYSTAL_PIN;
                3'h3: src_decode = SRC_MASTER;
                3'h4: src_decode = SRC_DPLL;
                3'h6: src_decode = SRC_DPLL;
                3'h7: src_decode = SRC_DPLL;
                default: src_decode = SRC_NONE;
            endcase
        end
    endfunction

    //////////////////////////////////////////////////////////////////////
    // pin synchronisers
    reg switch_meta_reg;
    reg switch_sync_reg;
    reg crystal_meta_reg;
    reg crystal_sync_reg;
    reg dpll_meta_reg;
    reg dpll_sync_reg;

    always @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            switch_meta_reg <= 1'b0;
            switch_sync_reg <= 1'b0;
            crystal_meta_reg <= 1'b0;
            crystal_sync_reg <= 1'b0;
            dpll_meta_reg <= 1'b0;
            dpll_sync_reg <= 1'b0;
        end else begin
            switch_meta_reg <= I_SWITCH_PIN;
            switch_sync_reg <= switch_meta_reg;
            crystal_meta_reg <= I_CRYSTAL_PRESENT;
            crystal_sync_reg <= crystal_meta_reg;
            dpll_meta_reg <= I_DPLL_EXTERNAL_SWITCH_MODE;
            dpll_sync_reg <= dpll_meta_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // wishbone slave
    reg [7:0] bank_reg;
    reg [7:0] bank_next;
    reg [7:0] cfg_one_reg [0:1];
    reg [7:0] cfg_two_reg [0:1];
    reg [7:0] one_next;
    reg [7:0] two_next;
    reg [31:0] rdat_next;
    integer k;

    wire req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
    wire [7:0] idx = I_WB_ADR[9:2];
    wire hit_sel = reg_hit(idx, `OFS_BANK_SELECT);
    wire hit_one = reg_hit(idx, `OFS_CONFIG_ONE);
    wire hit_two = reg_hit(idx, `OFS_CONFIG_TWO);
    wire bank_ok = bank_valid(bank_reg[1:0]);
    wire bank_idx = bank_reg[1];
    wire wr = req & I_WB_WE & I_WB_SEL[0];
    wire rd = req & ~I_WB_WE;

    // every access is acked, unmapped ones included
    assign O_WB_ERR = 1'b0;

    //////////////////////////////////////////////////////////////////////
    // read data mux

    always @* begin
        rdat_next = 32'h0;
        if (rd) begin
            if (hit_sel) begin
                rdat_next = {30'h0, bank_reg[1:0]};
            end else if (hit_one && bank_ok) begin
                rdat_next = {24'h0, cfg_one_reg[bank_idx]};
            end else if (hit_two && bank_ok) begin
                rdat_next = {24'h0, cfg_two_reg[bank_idx]};
            end
        end
    end

    always @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= 32'h0;
        end else begin
            O_WB_ACK <= req;
            O_WB_DAT <= rdat_next;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // register writes

    always @* begin
        bank_next = bank_reg;
        if (wr && hit_sel) begin
            bank_next = {6'h0, I_WB_DAT[1:0]};
        end
    end

    // only the copy chosen by the bank field is touched
    always @* begin
        one_next = cfg_one_reg[bank_idx];
        two_next = cfg_two_reg[bank_idx];
        if (wr && hit_one) begin
            one_next = I_WB_DAT[7:0] & 8'hEF; // bit 4 reserved
        end
        if (wr && hit_two) begin
            two_next = I_WB_DAT[7:0];
        end
    end

    always @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            bank_reg <= `RST_BANK_SELECT;
            for (k = 0; k < 2; k = k + 1) begin
                cfg_one_reg[k] <= `RST_CONFIG_ONE;
                cfg_two_reg[k] <= `RST_CONFIG_TWO;
            end
        end else begin
            bank_reg <= bank_next;
            if (bank_ok) begin
                cfg_one_reg[bank_idx] <= one_next;
                cfg_two_reg[bank_idx] <= two_next;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // per pll controls

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : per_pll
            wire [7:0] one_q = cfg_one_reg[g];
            wire [7:0] two_q = cfg_two_reg[g];
            wire use_alt = two_q[`POS_EXTERNAL_SWITCH_MODE] & switch_sync_reg;
            reg align_prev_reg;
            reg pulse_reg;
            reg pulse_next;
            reg enable_reg;
            reg enable_next;
            reg bypass_reg;
            reg bypass_next;
            reg [3:0] high_speed_divider_reg;
            reg [3:0] high_speed_divider_next;
            reg [3:0] ratio_reg;
            reg [3:0] ratio_next;
            reg [2:0] source_reg;
            reg [2:0] source_next;

            // one pulse per rising change of the align bit
            always @* begin
                pulse_next = one_q[`POS_ALIGN] & ~align_prev_reg;
            end

            always @* begin
                enable_next = one_q[`POS_ENABLE];
                bypass_next = one_q[`POS_BYPASS];
                high_speed_divider_next = one_q[`HIGH_SPEED_DIVIDER_HI:`HIGH_SPEED_DIVIDER_LO];
                ratio_next = in_ratio(two_q[`INPUT_DIVIDER_RATIO_HI:`INPUT_DIVIDER_RATIO_LO]);
            end

            // alternate field only counts in external switching mode
            always @* begin
                if (use_alt) begin
                    source_next = src_decode({1'b0, two_q[`ALT_HI:`ALT_LO]},
                        crystal_sync_reg);
                end else begin
                    source_next = src_decode(two_q[`PRI_HI:`PRI_LO],
                        crystal_sync_reg);
                end
            end

            always @(posedge I_CORE_CLK or negedge I_RSTN) begin
                if (!I_RSTN) begin
                    align_prev_reg <= 1'b0;
                    pulse_reg <= 1'b0;
                    enable_reg <= 1'b0;
                    bypass_reg <= 1'b0;
                    high_speed_divider_reg <= 4'h0;
                    ratio_reg <= 4'h1;
                    source_reg <= SRC_IN_ONE;
                end else begin
                    align_prev_reg <= one_q[`POS_ALIGN];
                    pulse_reg <= pulse_next;
                    enable_reg <= enable_next;
                    bypass_reg <= bypass_next;
                    high_speed_divider_reg <= high_speed_divider_next;
                    ratio_reg <= ratio_next;
                    source_reg <= source_next;
                end
            end

            assign O_ALIGN_PULSE[g] = pulse_reg;
            assign O_PLL_ENABLE[g] = enable_reg;
            assign O_PLL_BYPASS[g] = bypass_reg;
            assign O_HIGH_SPEED_DIVIDER_HALVES[4*g +: 4] = high_speed_divider_reg;
            assign O_INDIV_RATIO[4*g +: 4] = ratio_reg;
            assign O_SOURCE_SEL[3*g +: 3] = source_reg;
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////
    // shared switch pin role

    always @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_SWITCH_PIN_ACTIVE <= 1'b0;
        end else begin
            O_SWITCH_PIN_ACTIVE <= cfg_two_reg[0][`POS_EXTERNAL_SWITCH_MODE] | cfg_two_reg[1][`POS_EXTERNAL_SWITCH_MODE]
                | dpll_sync_reg;
        end
    end

endmodule

// >>> logic/pll_config_map.vh
`ifndef PLL_CONFIG_MAP_VH
`define PLL_CONFIG_MAP_VH

// register indices; byte address is four times the index
`define OFS_BANK_SELECT 8'h10
`define OFS_CONFIG_ONE 8'h11
`define OFS_CONFIG_TWO 8'h12

`define RST_BANK_SELECT 8'h01
`define RST_CONFIG_ONE 8'h00
`define RST_CONFIG_TWO 8'h00

`define BANK_PLL_ONE 2'h1
`define BANK_PLL_TWO 2'h2

// config one fields
`define POS_ENABLE 7
`define POS_BYPASS 6
`define POS_ALIGN 5
`define HIGH_SPEED_DIVIDER_HI 3
`define HIGH_SPEED_DIVIDER_LO 0

// config two fields
`define INPUT_DIVIDER_RATIO_HI 7
`define INPUT_DIVIDER_RATIO_LO 6
`define POS_EXTERNAL_SWITCH_MODE 5
`define ALT_HI 4
`define ALT_LO 3
`define PRI_HI 2
`define PRI_LO 0

`endif
